// ---- include/fwd_pkg.sv ----
/*
  Shared constants and types for the video forwarding mode control block:
  register offsets, field positions, reset values, sync modes, beat and
  register request layouts.
  Assumes it is compiled before any file of the block.
*/
package fwd_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int NUM_RX     = 4;
  localparam int NUM_OUT    = 2;
  localparam int DATA_W     = 16;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_CTL = 8'h20;
  localparam logic [7:0] ADDR_MODE_CTL = 8'h21;
  localparam logic [7:0] ADDR_STATUS   = 8'h22;
  localparam logic [7:0] RST_PORT_CTL  = 8'hF0;
  localparam logic [7:0] RST_MODE_CTL  = 8'h03;
  localparam logic [7:0] RST_STATUS    = 8'h00;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int POS_MAP       = 0;  // port_forward_control, 4 bits
  localparam int POS_DIS       = 4;  // port_forward_control, 4 bits
  localparam int POS_RR0       = 0;  // forwarding_mode_control, 1 bit per out
  localparam int POS_SYNC0     = 2;  // forwarding_mode_control, 2 bits per out
  localparam int POS_AS_AVAIL  = 6;
  localparam int POS_REPLICATE = 7;
  localparam int POS_LIVE      = 0;  // forwarding_status, 1 bit per out
  localparam int POS_FAIL      = 2;  // forwarding_status, 1 bit per out

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SYNC_OFF,
    SYNC_BASIC,
    SYNC_INTERLEAVE,
    SYNC_CONCAT
  } sync_mode_t;

  typedef struct packed {
    logic              fs;
    logic              fe;
    logic [1:0]        src;
    logic [DATA_W-1:0] data;
  } beat_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ---- hw/video_forwarding_mode_control.sv ----
/*
  Forwarding engines of a four-input, two-output video hub, with their
  control and status registers, and the output FIFO module they feed.
  Assumes receive ports and the register master run on clk_sys; each
  receive port holds valid and its beat until it sees a pop pulse.
*/
// Added by the designer: strobed register access.
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// Output FIFO
// ------------------------------------------------------------------------
module fwd_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // Filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             in_ready,
  // Draining side
  output      logic             out_valid,
  output      logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // Output stage is a register so the block's outputs come from flops
  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = (count_q != '0) && (!out_valid || out_ready);

  // Storage write
  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      wr_q    <= '0;
      rd_q    <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Show-ahead output register
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_data  <= mem_q[rd_q];
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end
endmodule

// Contract
// - Each output's two-bit sync selector means off, basic, interleave, concat; out0 at 3:2.
// - Bit 1 enables round-robin forwarding on output 1 and resets to 1.
// - Bit 0 enables round-robin forwarding on output 0, resets to 1, and 0 disables it.
// - Round-robin forwarding makes no alignment attempt and grants pending ports in rotation.
// - In sync forwarding a detected loss of sync sets the failure flag, bit 3 out1, bit 2 out0.
// - A failure flag is set only after one complete synchronized frame has been sent.
// - Failure flags are sticky and clear when the status register is read.
// - Live bit 1 (out1) and 0 (out0) show that synchronized video is being delivered.
// - The live bit reads 0 whenever that output's sync selector is off.
// - Each receive port has a forwarding disable bit, all resetting to 1.
// - Each receive port's map bit sends it to output 0 or 1; software disables before remapping.
// - Sync forwarding waits for a line from every enabled mapped port unless send-when-ready, which concat mode ignores.
module video_forwarding_mode_control #(
  parameter int NUM_RX     = fwd_pkg::NUM_RX,
  parameter int FIFO_DEPTH = fwd_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              reset,
  // Register port
  input  wire fwd_pkg::reg_req_t                 reg_req,
  output      logic [7:0]                        reg_rdata,
  // Receive ports
  input  wire logic [NUM_RX-1:0]                 rx_valid,
  input  wire fwd_pkg::beat_t [NUM_RX-1:0]       rx_beat,
  output      logic [NUM_RX-1:0]                 rx_pop,
  // Output streams
  output      logic [fwd_pkg::NUM_OUT-1:0]       out_valid,
  output      fwd_pkg::beat_t [fwd_pkg::NUM_OUT-1:0] out_beat,
  input  wire logic [fwd_pkg::NUM_OUT-1:0]       out_ready
);
  localparam int NO = fwd_pkg::NUM_OUT;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Lowest set bit at or after ptr, wrapping; {found, index}
  function automatic logic [2:0] rr_pick(logic [3:0] req, logic [1:0] ptr);
    logic [2:0] r;
    logic [1:0] k;
    r = 3'h0;
    for (int i = 3; i >= 0; i--)
    begin
      k = ptr + 2'(i);
      if (req[k])
      begin
        r = {1'b1, k};
      end
    end
    return r;
  endfunction

  function automatic fwd_pkg::sync_mode_t sync_sel(logic [7:0] ctl, int o);
    return fwd_pkg::sync_mode_t'(ctl[fwd_pkg::POS_SYNC0 + 2*o +: 2]);
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [7:0]    port_ctl_q;
  logic [7:0]    mode_ctl_q;
  logic [NO-1:0] live_q;
  logic [NO-1:0] fail_q;
  logic [NO-1:0] seen_q;
  logic [3:0]    set_q [NO];
  logic [1:0]    ptr_q [NO];

  logic [3:0]           dis;
  logic [3:0]           map;
  logic                 as_avail;
  logic [3:0]           members [NO];
  logic [3:0]           elig [NO];
  logic [NO-1:0]        pick_v;
  logic [1:0]           pick_i [NO];
  logic [NO-1:0]        pick_rr;
  logic [NO-1:0]        latch;
  logic [NO-1:0]        mismatch;
  logic [NO-1:0]        frame_ok;
  logic [NO-1:0]        fifo_ready;
  fwd_pkg::beat_t [NO-1:0] push_beat;
  logic [3:0]           pop_d;
  logic                 status_rd;

  assign dis       = port_ctl_q[fwd_pkg::POS_DIS +: 4];
  assign map       = port_ctl_q[fwd_pkg::POS_MAP +: 4];
  assign as_avail  = mode_ctl_q[fwd_pkg::POS_AS_AVAIL];
  assign status_rd = reg_req.rd && (reg_req.addr == fwd_pkg::ADDR_STATUS);

  // Control register writes
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      port_ctl_q <= fwd_pkg::RST_PORT_CTL;
      mode_ctl_q <= fwd_pkg::RST_MODE_CTL;
    end
    else if (reg_req.wr)
    begin
      if (reg_req.addr == fwd_pkg::ADDR_PORT_CTL)
      begin
        port_ctl_q <= reg_req.wdata;
      end
      if (reg_req.addr == fwd_pkg::ADDR_MODE_CTL)
      begin
        mode_ctl_q <= reg_req.wdata;
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_req.rd)
    begin
      case (reg_req.addr)
        fwd_pkg::ADDR_PORT_CTL: reg_rdata <= port_ctl_q;
        fwd_pkg::ADDR_MODE_CTL: reg_rdata <= mode_ctl_q;
        fwd_pkg::ADDR_STATUS:   reg_rdata <= {4'h0, fail_q, live_q};
        default:                reg_rdata <= 8'h00;
      endcase
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // Forwarding engines
  // ----------------------------------------------------------------------
  // Grant selection. A port popped last cycle is skipped once, since its
  // source has not yet had a chance to present the next beat.
  always_comb
  begin
    pop_d = '0;
    for (int o = 0; o < NO; o++)
    begin
      fwd_pkg::sync_mode_t md;
      logic [2:0] pk;
      logic [3:0] fs_m;
      logic [3:0] fe_m;
      md = sync_sel(mode_ctl_q, o);
      pk = 3'h0;
      for (int p = 0; p < 4; p++)
      begin
        members[o][p] = !dis[p] && (map[p] == o[0]);
        fs_m[p] = rx_beat[p].fs;
        fe_m[p] = rx_beat[p].fe;
      end
      elig[o]     = members[o] & rx_valid & ~rx_pop;
      pick_v[o]   = 1'b0;
      pick_i[o]   = 2'h0;
      pick_rr[o]  = 1'b0;
      latch[o]    = 1'b0;
      // Beats of a latched set must agree on frame start and end
      mismatch[o] = ((fs_m & members[o]) != '0) && ((fs_m | ~members[o]) != 4'hF);
      mismatch[o] = mismatch[o] ||
                    (((fe_m & members[o]) != '0) && ((fe_m | ~members[o]) != 4'hF));
      frame_ok[o] = !mismatch[o] && ((fe_m | ~members[o]) == 4'hF);
      if (set_q[o] != '0)
      begin
        pk = rr_pick(set_q[o] & elig[o], 2'h0);  // drain the aligned set
      end
      else if (md != fwd_pkg::SYNC_OFF &&
               !(as_avail && md != fwd_pkg::SYNC_CONCAT))
      begin
        // Hold until every enabled mapped port has a line
        latch[o] = (members[o] != '0) && ((members[o] & ~elig[o]) == '0);
      end
      else if (md != fwd_pkg::SYNC_OFF || mode_ctl_q[fwd_pkg::POS_RR0 + o])
      begin
        pk = rr_pick(elig[o], ptr_q[o]);
        pick_rr[o] = pk[2];
      end
      pick_v[o] = pk[2] && fifo_ready[o];
      pick_i[o] = pk[1:0];
      push_beat[o]     = rx_beat[pk[1:0]];
      push_beat[o].src = pk[1:0];
      if (pick_v[o])
      begin
        pop_d[pk[1:0]] = 1'b1;
      end
    end
  end

  // Pop pulses to the receive ports
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      rx_pop <= '0;
    end
    else
    begin
      rx_pop <= pop_d;
    end
  end

  // Aligned set and rotation pointer per output
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      for (int o = 0; o < NO; o++)
      begin
        set_q[o] <= '0;
        ptr_q[o] <= '0;
      end
    end
    else
    begin
      for (int o = 0; o < NO; o++)
      begin
        if (latch[o])
        begin
          set_q[o] <= members[o];
        end
        else
        begin
          // Ports disabled mid-set drop out rather than stall the output
          set_q[o] <= set_q[o] & members[o] & ~(pick_v[o] ? 4'(1 << pick_i[o]) : 4'h0);
        end
        if (pick_v[o] && pick_rr[o])
        begin
          ptr_q[o] <= pick_i[o] + 2'h1;
        end
      end
    end
  end

  // Synchronization tracking: live, frame seen, failure flag
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      live_q <= '0;
      seen_q <= '0;
      fail_q <= '0;
    end
    else
    begin
      for (int o = 0; o < NO; o++)
      begin
        if (sync_sel(mode_ctl_q, o) == fwd_pkg::SYNC_OFF)
        begin
          live_q[o] <= 1'b0;
          seen_q[o] <= 1'b0;
        end
        else if (latch[o] && mismatch[o])
        begin
          live_q[o] <= 1'b0;
          seen_q[o] <= 1'b0;
        end
        else if (latch[o] && frame_ok[o])
        begin
          live_q[o] <= 1'b1;
          seen_q[o] <= 1'b1;
        end
        // A new failure in the reading cycle survives the clear
        if (latch[o] && mismatch[o] && seen_q[o])
        begin
          fail_q[o] <= 1'b1;
        end
        else if (status_rd)
        begin
          fail_q[o] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output buffering
  // ----------------------------------------------------------------------
  for (genvar o = 0; o < NO; o++)
  begin : g_out
    fwd_fifo #(
      .WIDTH ($bits(fwd_pkg::beat_t)),
      .DEPTH (FIFO_DEPTH)
    ) u_fifo (
      .clk_sys   (clk_sys),
      .reset     (reset),
      .in_valid  (pick_v[o]),
      .in_data   (push_beat[o]),
      .in_ready  (fifo_ready[o]),
      .out_valid (out_valid[o]),
      .out_data  (out_beat[o]),
      .out_ready (out_ready[o])
    );
  end
endmodule

// ---- dv/fwd_checker_properties.sv ----
/*
  Port-level checker for the forwarding block: register reads, pops, routing.
  Assumes fwd_pkg is compiled first; bound to every top-module instance.
*/
`timescale 1ns/1ps
module fwd_checker #(
  parameter int NUM_RX = fwd_pkg::NUM_RX
) (
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 reset,
  // Register port
  input wire fwd_pkg::reg_req_t    reg_req,
  input wire logic [7:0]           reg_rdata,
  // Streams
  input wire logic [NUM_RX-1:0]    rx_valid,
  input wire logic [NUM_RX-1:0]    rx_pop,
  input wire logic [1:0]           out_valid,
  input wire fwd_pkg::beat_t [1:0] out_beat,
  input wire logic [1:0]           out_ready
);
  // ----------------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------------
  logic [7:0]        port_q;
  logic [7:0]        mode_q;
  logic [NUM_RX-1:0] dis;
  logic [1:0]        sync_on;
  logic              rd_port;
  logic              rd_mode;
  logic              rd_sts;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Decoded reads and fields; shadows follow writes only
  assign dis = NUM_RX'(port_q[7:4]);
  assign sync_on = {|mode_q[5:4], |mode_q[3:2]};
  assign rd_port = reg_req.rd && reg_req.addr == fwd_pkg::ADDR_PORT_CTL;
  assign rd_mode = reg_req.rd && reg_req.addr == fwd_pkg::ADDR_MODE_CTL;
  assign rd_sts = reg_req.rd && reg_req.addr == fwd_pkg::ADDR_STATUS;
  // Shadow copy of control, so reads can be judged without the body
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
    begin
      port_q <= fwd_pkg::RST_PORT_CTL;
      mode_q <= fwd_pkg::RST_MODE_CTL;
    end
    else if (reg_req.wr)
    begin
      if (reg_req.addr == fwd_pkg::ADDR_PORT_CTL) port_q <= reg_req.wdata;
      if (reg_req.addr == fwd_pkg::ADDR_MODE_CTL) mode_q <= reg_req.wdata;
    end
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  a_status_upper: assert property ($past(rd_sts) |-> reg_rdata[7:4] == 4'h0)
    else $error("reserved status bits set");
  a_mode_read: assert property ($past(rd_mode) |-> reg_rdata == $past(mode_q))
    else $error("mode control read back wrong");
  a_port_read: assert property ($past(rd_port) |-> reg_rdata == $past(port_q))
    else $error("port control read back wrong");
  a_live_off: assert property ($past(rd_sts) |-> (reg_rdata[1:0] & ~$past(sync_on)) == 2'h0)
    else $error("live bit set with sync off");
  a_pop_gap: assert property ((rx_pop & $past(rx_pop)) == '0)
    else $error("port popped two cycles running");
  a_pop_valid: assert property ((rx_pop & ~$past(rx_valid)) == '0)
    else $error("pop without pending beat");
  a_pop_dis: assert property ((rx_pop & dis & $past(dis)) == '0)
    else $error("disabled port popped");
  a_out_hold: assert property (out_valid[0] && !out_ready[0] |=>
      out_valid[0] && $stable(out_beat[0]))
    else $error("output beat dropped before accept");
  a_route_zero: assert property (out_valid[0] |-> !port_q[out_beat[0].src])
    else $error("beat on output 0 from port mapped to 1");
  a_route_one: assert property (out_valid[1] |-> port_q[out_beat[1].src])
    else $error("beat on output 1 from port mapped to 0");
endmodule

bind video_forwarding_mode_control fwd_checker #(.NUM_RX(NUM_RX)) u_chk (
  .clk_sys(clk_sys), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .rx_valid(rx_valid), .rx_pop(rx_pop), .out_valid(out_valid),
  .out_beat(out_beat), .out_ready(out_ready));

// ---- dv/video_sink.sv ----
/*
  Consumer model for both output streams: ready, withheld on request.
  Assumes the bench drives hold for stalls and slow phases.
*/
`timescale 1ns/1ps
module video_sink (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset,
  // Stream side
  input  wire logic [1:0] out_valid,
  output      logic [1:0] out_ready,
  // Bench control
  input  wire logic [1:0] hold
);
  // ----------------------------------------------------------------------
  // Ready, registered so a stall lands a cycle late, as real logic would
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset)
    if (reset)
      out_ready <= 2'h0;
    else
      out_ready <= ~hold;
endmodule

// ---- dv/testbench.sv ----
/*
  Self-checking bench: register port, four sources, two consumers.
  Assumes fwd_pkg, the design, its checker and the sink model.
*/
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------------------------------------
  // Signals and notes
  // ----------------------------------------------------------------------
  localparam logic [7:0] PC = fwd_pkg::ADDR_PORT_CTL;
  localparam logic [7:0] MC = fwd_pkg::ADDR_MODE_CTL;
  localparam logic [7:0] ST = fwd_pkg::ADDR_STATUS;
  logic clk_sys, reset, slow, rd_seen;
  fwd_pkg::reg_req_t reg_req;
  logic [7:0] reg_rdata, v;
  logic [3:0] rx_valid, rx_pop, map_q;
  logic [1:0] out_valid, out_ready, hold, stall, last_src;
  fwd_pkg::beat_t [3:0] rx_beat;
  fwd_pkg::beat_t [1:0] out_beat;
  logic [7:0] rd_q[$];
  fwd_pkg::beat_t src_q[4][$];
  fwd_pkg::beat_t exp_q[4][$];
  int pops[4];
  int error_cnt, check_count;
  video_forwarding_mode_control #(.NUM_RX(4), .FIFO_DEPTH(16)) uut (.clk_sys(clk_sys),
    .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
    .rx_beat(rx_beat), .rx_pop(rx_pop), .out_valid(out_valid), .out_beat(out_beat),
    .out_ready(out_ready));
  video_sink sink (.clk_sys(clk_sys), .reset(reset), .out_valid(out_valid),
    .out_ready(out_ready), .hold(hold));
  // 50 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One strobe cycle, then an idle cycle, so no signal is driven twice
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    if (!w) rd_q.push_back(d);
    @(posedge clk_sys);
    reg_req <= '{wr: w, rd: !w, addr: a, wdata: w ? d : 8'h00};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask
  // Source input carries a random src; the block must replace it
  task automatic push(input int i, input logic fs, input logic fe);
    fwd_pkg::beat_t b;
    b = {fs, fe, 2'($urandom), 16'($urandom)};
    src_q[i].push_back(b);
    b.src = 2'(i);
    exp_q[i].push_back(b);
  endtask
  task automatic frame();
    push(0, 1'b1, 1'b0);
    push(1, 1'b1, 1'b0);
    push(0, 1'b0, 1'b1);
    push(1, 1'b0, 1'b1);
  endtask
  // Bounded wait until every noted beat has come out
  task automatic drain();
    int n;
    for (n = 0; n < 800; n++)
    begin
      if (exp_q[0].size() + exp_q[1].size() + exp_q[2].size() + exp_q[3].size() == 0) break;
      @(posedge clk_sys);
    end
    if (n == 800)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: output stream hung", $time);
      finish_test();
    end
  endtask
  // ----------------------------------------------------------------------
  // Sources, consumer pacing and output monitor
  // ----------------------------------------------------------------------
  // Sources hold a beat until popped; idle data toggles so stale values never pass
  always @(posedge clk_sys)
    for (int i = 0; i < 4; i++)
    begin
      if (rx_pop[i]) pops[i]++;
      if (rx_pop[i] || !rx_valid[i])
      begin
        rx_valid[i] <= src_q[i].size() > 0;
        rx_beat[i] <= src_q[i].size() > 0 ? src_q[i].pop_front() : ~rx_beat[i];
      end
    end
  always @(posedge clk_sys)
    hold <= stall | (slow ? 2'($urandom) : 2'h0);
  // Takes the oldest note whenever a read answer or an output beat appears
  always @(posedge clk_sys)
  begin
    if (rd_seen) chk(32'(reg_rdata), 32'(rd_q.pop_front()));
    rd_seen <= reg_req.rd;
    for (int o = 0; o < 2; o++)
      if (out_valid[o] && out_ready[o])
      begin
        chk(32'(map_q[out_beat[o].src]), 32'(o));
        if (exp_q[out_beat[o].src].size() == 0) chk(32'h0, 32'h1);
        else chk(32'(out_beat[o]), 32'(exp_q[out_beat[o].src].pop_front()));
        if (o == 0 && rx_valid[out_beat[0].src ^ 2'h1]) chk(32'(out_beat[0].src == last_src), 0);
        if (o == 0) last_src = out_beat[0].src;
      end
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h7D87527D));
    {reset, reg_req, rx_valid, rx_beat, stall, slow, hold, rd_seen} = '0;
    reset = 1'b1;
    map_q = 4'h0;
    last_src = 2'h3;
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    bus(0, PC, 8'hF0);
    bus(0, MC, 8'h03);
    bus(1, ST, 8'hFF);
    bus(0, ST, 8'h00);
    bus(0, 8'h30, 8'h00);
    v = 8'($urandom) & 8'hFC;
    bus(1, MC, v);
    bus(0, MC, v);
    bus(1, MC, 8'h03);
    // Round-robin on both outputs, slow consumer
    slow <= 1'b1;
    map_q = 4'h4;
    bus(1, PC, 8'h84);
    for (int k = 0; k < 6; k++)
    begin
      push(0, 1'b0, 1'b0);
      push(1, 1'b0, 1'b0);
      push(2, 1'b0, 1'b0);
    end
    drain();
    // Buffer fills until it refuses, then drains
    stall <= 2'h1;
    repeat (4) @(posedge clk_sys);
    pops[0] = 0;
    for (int k = 0; k < 20; k++) push(0, 1'b0, 1'b0);
    repeat (80) @(posedge clk_sys);
    chk(pops[0], fwd_pkg::FIFO_DEPTH + 1);
    stall <= 2'h0;
    drain();
    // Round-robin off on output 0 only
    bus(1, MC, 8'h02);
    pops[0] = 0;
    push(0, 1'b0, 1'b0);
    push(2, 1'b0, 1'b0);
    repeat (20) @(posedge clk_sys);
    chk(pops[0], 0);
    chk(exp_q[2].size(), 0);
    bus(1, MC, 8'h03);
    drain();
    // Disable before remapping, then every sync mode on output 0
    bus(1, PC, 8'hC4);
    map_q = 4'h0;
    bus(1, PC, 8'hC0);
    for (int m = 1; m < 4; m++)
    begin
      bus(1, MC, 8'(m << 2));
      pops[0] = 0;
      push(0, 1'b1, 1'b0);
      repeat (8) @(posedge clk_sys);
      chk(pops[0], 0);
      push(1, 1'b0, 1'b0);
      drain();
      bus(0, ST, 8'h00);
      frame();
      drain();
      bus(0, ST, 8'h01);
      push(0, 1'b1, 1'b0);
      push(1, 1'b0, 1'b0);
      drain();
      bus(0, 8'h30, 8'h00);
      bus(0, ST, 8'h04);
      bus(0, ST, 8'h00);
    end
    frame();
    drain();
    bus(0, ST, 8'h01);
    bus(1, MC, 8'h00);
    bus(0, ST, 8'h00);
    finish_test();
  end
endmodule
